// ### logic/instr_format_decode.sv
// instruction word decoder with load/store lanes and pipeline interlocks
`timescale 1ns/1ps
module instr_format_decode
  import instr_decode_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] instr_pc,
  input wire logic [31:0] src_a_value,
  input wire logic [31:0] second_value,
  input wire logic [31:0] store_value,
  input wire logic big_endian,
  output logic stall,
  output logic fetch_err,
  output logic [5:0] primary_code_field,
  output logic [4:0] source_a_index,
  output logic [4:0] second_operand_index,
  output logic [4:0] dest_index,
  output logic [4:0] shift_count_field,
  output logic [5:0] minor_code_field,
  output logic [15:0] imm_field,
  output logic [25:0] jump_field,
  output logic [31:0] operand_b,
  output logic [31:0] jump_target,
  output logic [31:0] branch_target,
  output logic mem_valid,
  output logic mem_write,
  output logic [3:0] mem_lanes,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic addr_err,
  output logic mul_issue
);
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;
  // held decode state
  logic [31:0] word_r;
  logic [31:0] word_nxt;
  logic [31:0] pc_r;
  logic [31:0] pc_nxt;
  logic [31:0] opb_r;
  logic [31:0] opb_nxt;
  logic [31:0] jt_r;
  logic [31:0] jt_nxt;
  logic [31:0] bt_r;
  logic [31:0] bt_nxt;
  logic ferr_r;
  logic ferr_nxt;
  logic mv_r;
  logic mv_nxt;
  logic mw_r;
  logic mw_nxt;
  logic [3:0] ml_r;
  logic [3:0] ml_nxt;
  logic [31:0] ma_r;
  logic [31:0] ma_nxt;
  logic [31:0] md_r;
  logic [31:0] md_nxt;
  logic ae_r;
  logic ae_nxt;
  logic mi_r;
  logic mi_nxt;
  logic stall_r;
  logic stall_nxt;
  // previous load destination
  logic load_pend_r;
  logic load_pend_nxt;
  logic [4:0] load_dst_r;
  logic [4:0] load_dst_nxt;
  // decode of the incoming word
  logic [5:0] prim;
  logic [5:0] minor;
  logic is_load;
  logic is_store;
  logic is_mem;
  logic is_reg_fmt;
  access_size_type size;
  logic [31:0] eff_addr;
  logic [3:0] lanes;
  logic lane_err;
  logic is_mult;
  logic is_read_prod;
  logic mul_busy;
  logic mul_done;
  logic load_use;
  logic prod_wait;
  logic take;
  logic [1:0] rot;
  logic [1:0] span;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  assign prim = instr_word[31:PRIM_LSB];
  assign minor = instr_word[5:MINOR_LSB];
  assign is_reg_fmt = (prim == PRIM_SPECIAL);

  always_comb
  begin
    is_load = 1'b0;
    is_store = 1'b0;
    size = SIZE_WORD;
    unique case (prim)
      PRIM_LOAD_BYTE, PRIM_LOAD_BYTE_U:
      begin
        is_load = 1'b1;
        size = SIZE_BYTE;
      end
      PRIM_LOAD_HALF, PRIM_LOAD_HALF_U:
      begin
        is_load = 1'b1;
        size = SIZE_HALF;
      end
      PRIM_LOAD_LEFT, PRIM_LOAD_RIGHT:
      begin
        is_load = 1'b1;
        size = SIZE_TRIPLE;
      end
      PRIM_LOAD_WORD, PRIM_LOAD_LINKED:
      begin
        is_load = 1'b1;
      end
      PRIM_STORE_BYTE:
      begin
        is_store = 1'b1;
        size = SIZE_BYTE;
      end
      PRIM_STORE_HALF:
      begin
        is_store = 1'b1;
        size = SIZE_HALF;
      end
      PRIM_STORE_LEFT, PRIM_STORE_RIGHT:
      begin
        is_store = 1'b1;
        size = SIZE_TRIPLE;
      end
      PRIM_STORE_WORD, PRIM_STORE_COND:
      begin
        is_store = 1'b1;
      end
      default:
      begin
        is_load = 1'b0;
      end
    endcase
  end
  assign is_mem = is_load | is_store;
  assign eff_addr = src_a_value + {{16{instr_word[15]}}, instr_word[15:0]};

  lane_select u_lanes (
    .size(size),
    .addr_low(eff_addr[2:0]),
    .big_endian(big_endian),
    .lanes(lanes),
    .addr_err(lane_err)
  );

  // multiplies run in the side unit
  assign is_mult = is_reg_fmt && (minor == MINOR_MULT || minor == MINOR_MULT_U);
  assign is_read_prod = is_reg_fmt && (minor == MINOR_READ_UPPER || minor == MINOR_READ_BOTTOM);

  mul_tracker #(
    .LAT(MUL_LAT)
  ) u_mul (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .issue(mi_nxt),
    .busy(mul_busy),
    .done(mul_done)
  );

  assign load_use = instr_valid && load_pend_r && (load_dst_r != 5'h00)
    && (instr_word[25:21] == load_dst_r || instr_word[20:16] == load_dst_r);
  // product read waits for the multiplier
  assign prod_wait = instr_valid && is_read_prod && mul_busy && !mul_done;
  assign take = instr_valid && !load_use && !prod_wait;
  // lane of the field's least significant byte; big endian counts back over the field length
  assign span = (size == SIZE_WORD) ? 2'h3 : (size == SIZE_TRIPLE) ? 2'h2 :
    (size == SIZE_HALF) ? 2'h1 : 2'h0;
  assign rot = big_endian ? 2'(~eff_addr[1:0] - span) : eff_addr[1:0];

  // next decode state
  always_comb
  begin
    word_nxt = word_r;
    pc_nxt = pc_r;
    opb_nxt = opb_r;
    jt_nxt = jt_r;
    bt_nxt = bt_r;
    ferr_nxt = 1'b0;
    mv_nxt = 1'b0;
    mw_nxt = 1'b0;
    ml_nxt = 4'h0;
    ma_nxt = ma_r;
    md_nxt = md_r;
    ae_nxt = 1'b0;
    mi_nxt = 1'b0;
    stall_nxt = instr_valid && !take;
    load_pend_nxt = 1'b0;
    load_dst_nxt = load_dst_r;
    if (take)
    begin
      word_nxt = instr_word;
      pc_nxt = instr_pc;
      ferr_nxt = (instr_pc[1:0] != 2'h0);
      opb_nxt = is_reg_fmt ? second_value : {{16{instr_word[15]}}, instr_word[15:0]};
      // jump target from pc top bits
      jt_nxt = {instr_pc[31:28], instr_word[25:0], 2'h0};
      bt_nxt = (instr_pc + 32'h4) + {{14{instr_word[15]}}, instr_word[15:0], 2'h0};
      ma_nxt = eff_addr;
      ae_nxt = is_mem && lane_err;
      mv_nxt = is_mem && !lane_err;
      mw_nxt = is_store && !lane_err;
      ml_nxt = is_mem ? lanes : 4'h0;
      // store data shifted so its low byte meets the field's least significant lane
      md_nxt = store_value << {rot, 3'h0};
      mi_nxt = is_mult;
      load_pend_nxt = is_load && !lane_err;
      load_dst_nxt = instr_word[20:16];
    end
    else if (load_use)
    begin
      // clear the load pending after one bubble so the consumer is taken next
      load_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word_r <= 32'h0;
      pc_r <= 32'h0;
      opb_r <= 32'h0;
      jt_r <= 32'h0;
      bt_r <= 32'h0;
      ferr_r <= 1'b0;
      mv_r <= 1'b0;
      mw_r <= 1'b0;
      ml_r <= 4'h0;
      ma_r <= 32'h0;
      md_r <= 32'h0;
      ae_r <= 1'b0;
      mi_r <= 1'b0;
      stall_r <= 1'b0;
      load_pend_r <= 1'b0;
      load_dst_r <= 5'h00;
    end
    else
    begin
      word_r <= word_nxt;
      pc_r <= pc_nxt;
      opb_r <= opb_nxt;
      jt_r <= jt_nxt;
      bt_r <= bt_nxt;
      ferr_r <= ferr_nxt;
      mv_r <= mv_nxt;
      mw_r <= mw_nxt;
      ml_r <= ml_nxt;
      ma_r <= ma_nxt;
      md_r <= md_nxt;
      ae_r <= ae_nxt;
      mi_r <= mi_nxt;
      stall_r <= stall_nxt;
      load_pend_r <= load_pend_nxt;
      load_dst_r <= load_dst_nxt;
    end
  end

  assign jump_field = word_r[25:0];
  assign primary_code_field = word_r[31:PRIM_LSB];
  assign source_a_index = word_r[25:SRCA_LSB];
  assign second_operand_index = word_r[20:SECOND_LSB];
  assign dest_index = word_r[15:DEST_LSB];
  assign shift_count_field = word_r[10:SHIFT_LSB];
  assign minor_code_field = word_r[5:MINOR_LSB];
  assign imm_field = word_r[15:0];
  assign operand_b = opb_r;
  assign jump_target = jt_r;
  assign branch_target = bt_r;
  assign fetch_err = ferr_r;
  assign mem_valid = mv_r;
  assign mem_write = mw_r;
  assign mem_lanes = ml_r;
  assign mem_addr = ma_r;
  assign mem_wdata = md_r;
  assign addr_err = ae_r;
  assign mul_issue = mi_r;
  assign stall = stall_r;

  // error and access never together
  err_blocks_access_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    addr_err |-> !mem_valid && mem_lanes == 4'h0)
    else $error("address error with access");
  // load use gives a stall
  load_use_stall_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load_use |=> stall)
    else $error("load use not stalled");
  // product read stalls while busy, except in the done cycle
  prod_read_stall_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    prod_wait |=> stall ##0 !mul_issue)
    else $error("early product read not stalled");
  // word access only full lanes
  word_lanes_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && is_mem && size == SIZE_WORD && !lane_err) |=> mem_lanes == 4'hf)
    else $error("word lanes wrong");
  // jump target top bits
  jump_target_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    take |=> jump_target == {pc_r[31:28], word_r[25:0], 2'h0})
    else $error("jump target wrong");
  // multiply issue shows the tracker busy
  mul_flow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mul_issue |-> mul_busy)
    else $error("multiply not tracked");
  // byte lane mirrored by order
  byte_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && is_mem && size == SIZE_BYTE && !lane_err && big_endian && eff_addr[1:0] == 2'h0)
    |=> mem_lanes == 4'h8)
    else $error("big endian byte lane wrong");
  // immediate operand sign extended
  imm_operand_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && !is_reg_fmt) |=> operand_b == {{16{imm_field[15]}}, imm_field})
    else $error("immediate operand wrong");
endmodule

// ### logic/instr_decode_pkg.sv
// shared constants for the instruction format decoder
package instr_decode_pkg;
  localparam int WORD_W = 32;
  localparam int IMM_W = 16;
  localparam int TGT_W = 26;
  localparam int IDX_W = 5;
  localparam int CODE_W = 6;
  // field positions
  localparam int PRIM_LSB = 26;
  localparam int SRCA_LSB = 21;
  localparam int SECOND_LSB = 16;
  localparam int DEST_LSB = 11;
  localparam int SHIFT_LSB = 6;
  localparam int MINOR_LSB = 0;
  // primary codes used here
  localparam logic [5:0] PRIM_SPECIAL = 6'h00;
  localparam logic [5:0] PRIM_JUMP = 6'h02;
  localparam logic [5:0] PRIM_JUMP_LINK = 6'h03;
  localparam logic [5:0] PRIM_LOAD_BYTE = 6'h20;
  localparam logic [5:0] PRIM_LOAD_HALF = 6'h21;
  localparam logic [5:0] PRIM_LOAD_LEFT = 6'h22;
  localparam logic [5:0] PRIM_LOAD_WORD = 6'h23;
  localparam logic [5:0] PRIM_LOAD_BYTE_U = 6'h24;
  localparam logic [5:0] PRIM_LOAD_HALF_U = 6'h25;
  localparam logic [5:0] PRIM_LOAD_RIGHT = 6'h26;
  localparam logic [5:0] PRIM_STORE_BYTE = 6'h28;
  localparam logic [5:0] PRIM_STORE_HALF = 6'h29;
  localparam logic [5:0] PRIM_STORE_LEFT = 6'h2a;
  localparam logic [5:0] PRIM_STORE_WORD = 6'h2b;
  localparam logic [5:0] PRIM_STORE_RIGHT = 6'h2e;
  localparam logic [5:0] PRIM_LOAD_LINKED = 6'h30;
  localparam logic [5:0] PRIM_STORE_COND = 6'h38;
  // minor codes of the multiply unit
  localparam logic [5:0] MINOR_READ_UPPER = 6'h10;
  localparam logic [5:0] MINOR_READ_BOTTOM = 6'h12;
  localparam logic [5:0] MINOR_MULT = 6'h18;
  localparam logic [5:0] MINOR_MULT_U = 6'h19;
  // multiplier latency in cycles after issue
  localparam int MUL_LAT = 4;
  localparam logic [3:0] MUL_CNT_RST = 4'h0;
  localparam logic [1:0] ENDIAN_LITTLE = 2'h0;
  // access sizes
  typedef enum logic [3:0] {
    SIZE_BYTE = 4'h1,
    SIZE_HALF = 4'h2,
    SIZE_TRIPLE = 4'h4,
    SIZE_WORD = 4'h8
  } access_size_type;
endpackage

// ### logic/lane_select.sv
// byte lane selector and alignment check for loads and stores
`timescale 1ns/1ps
module lane_select
  import instr_decode_pkg::*;
(
  input wire access_size_type size,
  input wire logic [2:0] addr_low,
  input wire logic big_endian,
  output logic [3:0] lanes,
  output logic addr_err
);
  logic [3:0] le_lanes;

  // lanes in little-endian numbering, then mirrored for big endian
  always_comb
  begin
    le_lanes = 4'h0;
    addr_err = 1'b0;
    unique case (size)
      SIZE_WORD:
      begin
        le_lanes = 4'hf;
        addr_err = (addr_low != 3'h0);
      end
      SIZE_TRIPLE:
      begin
        le_lanes = addr_low[0] ? 4'he : 4'h7;
        addr_err = (addr_low[2:1] != 2'h0);
      end
      SIZE_HALF:
      begin
        le_lanes = addr_low[1] ? 4'hc : 4'h3;
        addr_err = addr_low[2] | addr_low[0];
      end
      SIZE_BYTE:
      begin
        le_lanes = 4'h1 << addr_low[1:0];
        addr_err = addr_low[2];
      end
      default:
      begin
        le_lanes = 4'h0;
        addr_err = 1'b1;
      end
    endcase
    lanes = big_endian ? {le_lanes[0], le_lanes[1], le_lanes[2], le_lanes[3]} : le_lanes;
    if (addr_err)
    begin
      lanes = 4'h0;
    end
  end
endmodule

// ### logic/mul_tracker.sv
// multiplier busy tracker for the product read interlock
`timescale 1ns/1ps
module mul_tracker
  import instr_decode_pkg::*;
#(
  parameter int LAT = MUL_LAT
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic issue,
  output logic busy,
  output logic done
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  // count down the product latency
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (issue)
    begin
      cnt_nxt = 4'(LAT);
    end
    else if (cnt_r != 4'h0)
    begin
      cnt_nxt = cnt_r - 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= MUL_CNT_RST;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  assign busy = (cnt_r != 4'h0);
  assign done = (cnt_r == 4'h1);
endmodule

// ### verif/mem_model.sv
// data memory side model: counts accesses and merges stored lanes
`timescale 1ns/1ps
module mem_model
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic mem_valid,
  input wire logic mem_write,
  input wire logic [3:0] mem_lanes,
  input wire logic [31:0] mem_wdata,
  output logic [7:0] n_reads,
  output logic [7:0] n_writes,
  output logic [31:0] store_word
);
  // only enabled lanes take data
  // a refused access never pulses mem_valid, so counts expose it
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      n_reads <= 8'h00;
      n_writes <= 8'h00;
      store_word <= 32'h0000_0000;
    end
    else if (mem_valid && mem_write)
    begin
      n_writes <= n_writes + 8'h01;
      for (int i = 0; i < 4; i++)
        if (mem_lanes[i])
          store_word[8*i +: 8] <= mem_wdata[8*i +: 8];
    end
    else if (mem_valid)
      n_reads <= n_reads + 8'h01;
  end
endmodule

// ### verif/test_cpu_instr_format_decode.sv
// self-checking bench for the instruction format decoder
`timescale 1ns/1ps
module test_cpu_instr_format_decode;
  import instr_decode_pkg::*;
  logic clk_sys, rst_b, instr_valid, big_endian;
  logic [31:0] instr_word, instr_pc, src_a_value, second_value, store_value;
  logic stall, fetch_err, mem_valid, mem_write, addr_err, mul_issue;
  logic [5:0] primary_code_field, minor_code_field;
  logic [4:0] source_a_index, second_operand_index, dest_index, shift_count_field;
  logic [15:0] imm_field;
  logic [25:0] jump_field;
  logic [31:0] operand_b, jump_target, branch_target, mem_addr, mem_wdata, store_word;
  logic [3:0] mem_lanes;
  logic [7:0] n_reads, n_writes;
  int num_errors = 0;
  int n_checks = 0;

  instr_format_decode u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_pc(instr_pc), .src_a_value(src_a_value),
    .second_value(second_value), .store_value(store_value), .big_endian(big_endian),
    .stall(stall), .fetch_err(fetch_err), .primary_code_field(primary_code_field),
    .source_a_index(source_a_index), .second_operand_index(second_operand_index),
    .dest_index(dest_index), .shift_count_field(shift_count_field),
    .minor_code_field(minor_code_field), .imm_field(imm_field), .jump_field(jump_field),
    .operand_b(operand_b), .jump_target(jump_target), .branch_target(branch_target),
    .mem_valid(mem_valid), .mem_write(mem_write), .mem_lanes(mem_lanes),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .addr_err(addr_err),
    .mul_issue(mul_issue));

  mem_model u_mem (.clk_sys(clk_sys), .rst_b(rst_b), .mem_valid(mem_valid),
    .mem_write(mem_write), .mem_lanes(mem_lanes), .mem_wdata(mem_wdata),
    .n_reads(n_reads), .n_writes(n_writes), .store_word(store_word));

  // free-running core clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic conclude();
  begin
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  end
  endtask

  // byte order only changes under reset, since it is static
  task automatic do_reset(input logic be);
  begin
    @(posedge clk_sys);
    rst_b <= 1'b0;
    big_endian <= be;
    instr_valid <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk({stall, mem_valid, addr_err, mul_issue, fetch_err}, 32'h0);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
  end
  endtask

  // one word offered, taken at the next edge, outputs checked after it
  task automatic issue(input logic [31:0] w, input logic [31:0] pc);
  begin
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w;
    instr_pc <= pc;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    chk(stall, 32'h0);
  end
  endtask

  function automatic logic [4:0] lane_exp(input int sz, input int off, input logic be);
    logic [3:0] l;
    logic e;
    e = (sz == 0) ? (off > 3) : (sz == 1) ? (off != 0 && off != 2) : (sz == 2) ? (off > 1) :
      (off != 0);
    l = (sz == 0) ? 4'h1 << off[1:0] : (sz == 1) ? ((off == 2) ? 4'hc : 4'h3) :
      (sz == 2) ? ((off == 1) ? 4'he : 4'h7) : 4'hf;
    if (be)
      l = {l[0], l[1], l[2], l[3]};
    return {e, l};
  endfunction

  task automatic t_fields();
  begin
    issue({PRIM_SPECIAL, 5'h11, 5'h12, 5'h13, 5'h14, 6'h25}, 32'h0000_1000);
    chk({source_a_index, second_operand_index, dest_index, shift_count_field,
      minor_code_field}, {5'h11, 5'h12, 5'h13, 5'h14, 6'h25});
    chk(operand_b, 32'h5a5a_0001);
    chk(fetch_err, 32'h0);
    issue({6'h08, 5'h03, 5'h04, 16'h8001}, 32'h4000_0010);
    chk({primary_code_field, source_a_index, second_operand_index, imm_field},
      {6'h08, 5'h03, 5'h04, 16'h8001});
    chk(operand_b, 32'hffff_8001);
    chk(branch_target, 32'h3ffe_0018);
    issue({PRIM_JUMP, 26'h2ab_cdef}, 32'ha000_0000);
    chk({primary_code_field, jump_field}, {PRIM_JUMP, 26'h2ab_cdef});
    chk(jump_target, {4'ha, 26'h2ab_cdef, 2'b00});
    issue({6'h08, 5'h03, 5'h04, 16'h0001}, 32'h0000_1002);
    chk(fetch_err, 32'h1);
  end
  endtask

  // every size at every low address, legal ones counted by the memory
  task automatic t_lanes(input logic be);
    logic [4:0] e;
    logic [7:0] r0;
    logic [5:0] lds [4] = '{PRIM_LOAD_BYTE, PRIM_LOAD_HALF, PRIM_LOAD_LEFT, PRIM_LOAD_WORD};
    logic [5:0] ldu [4] = '{PRIM_LOAD_BYTE_U, PRIM_LOAD_HALF_U, PRIM_LOAD_RIGHT,
      PRIM_LOAD_LINKED};
  begin
    r0 = n_reads;
    for (int sz = 0; sz < 4; sz++)
      for (int off = 0; off < 8; off++)
      begin
        e = lane_exp(sz, off, be);
        // the second byte order runs the other opcode of each size
        issue({be ? ldu[sz] : lds[sz], 5'h01, 5'h00, 16'(off)}, 32'h0000_0200);
        chk(addr_err, e[4]);
        chk(mem_valid, !e[4]);
        if (!e[4])
          chk(mem_lanes, e[3:0]);
        if (!e[4])
          chk(mem_addr, 32'h100 + off);
      end
    chk(n_reads - r0, 32'h9);
  end
  endtask

  task automatic t_store(input logic be);
  begin
    @(posedge clk_sys);
    store_value <= 32'h1234_5678;
    issue({PRIM_STORE_WORD, 5'h01, 5'h00, 16'h0000}, 32'h0000_0300);
    chk({mem_write, mem_lanes}, 32'h1f);
    chk(mem_wdata, 32'h1234_5678);
    @(posedge clk_sys);
    store_value <= 32'h0000_00ab;
    issue({PRIM_STORE_BYTE, 5'h01, 5'h00, 16'h0003}, 32'h0000_0304);
    chk(mem_wdata, be ? 32'h0000_00ab : 32'hab00_0000);
    @(posedge clk_sys);
    #1;
    chk(store_word, be ? 32'h1234_56ab : 32'hab34_5678);
    // halfword store: big endian needs no shift at offset 2, little endian sixteen bits
    @(posedge clk_sys);
    store_value <= 32'h0000_cdef;
    issue({PRIM_STORE_HALF, 5'h01, 5'h00, 16'h0002}, 32'h0000_0308);
    chk(mem_lanes, be ? 32'h3 : 32'hc);
    chk(mem_wdata, be ? 32'h0000_cdef : 32'hcdef_0000);
    @(posedge clk_sys);
    #1;
    chk(store_word, be ? 32'h1234_cdef : 32'hcdef_5678);
  end
  endtask

  // consumer offered back to back after a load of its register
  task automatic t_load_use();
  begin
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= {PRIM_LOAD_WORD, 5'h01, 5'h05, 16'h0000};
    @(posedge clk_sys);
    instr_word <= {PRIM_SPECIAL, 5'h05, 5'h02, 5'h03, 5'h00, 6'h21};
    #1;
    chk(mem_valid, 32'h1);
    @(posedge clk_sys);
    #1;
    chk({stall, source_a_index}, {1'b1, 5'h01});
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    chk({stall, source_a_index, dest_index}, {1'b0, 5'h05, 5'h03});
    chk(operand_b, 32'h5a5a_0001);
  end
  endtask

  task automatic t_mul();
  begin
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= {PRIM_SPECIAL, 5'h01, 5'h02, 10'h000, MINOR_MULT_U};
    @(posedge clk_sys);
    instr_word <= {PRIM_SPECIAL, 5'h03, 5'h04, 5'h06, 5'h00, 6'h21};
    #1;
    chk(mul_issue, 32'h1);
    @(posedge clk_sys);
    instr_word <= {PRIM_SPECIAL, 5'h01, 5'h02, 10'h000, MINOR_MULT};
    #1;
    chk({stall, dest_index}, {1'b0, 5'h06});
    @(posedge clk_sys);
    instr_word <= {PRIM_SPECIAL, 10'h000, 5'h07, 5'h00, MINOR_READ_UPPER};
    for (int i = 0; i < MUL_LAT - 1; i++)
    begin
      @(posedge clk_sys);
      #1;
      chk(stall, 32'h1);
    end
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    chk({stall, minor_code_field}, {1'b0, MINOR_READ_UPPER});
    repeat (MUL_LAT + 2) @(posedge clk_sys);
    issue({PRIM_SPECIAL, 10'h000, 5'h08, 5'h00, MINOR_READ_BOTTOM}, 32'h0000_0400);
    chk(minor_code_field, MINOR_READ_BOTTOM);
  end
  endtask

  // a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    conclude();
  end

  initial
  begin
    rst_b = 1'b0;
    big_endian = 1'b0;
    instr_valid = 1'b0;
    instr_word = 32'h0;
    instr_pc = 32'h0;
    src_a_value = 32'h100;
    second_value = 32'h5a5a_0001;
    store_value = 32'h0;
    do_reset(1'b0);
    t_fields();
    t_lanes(1'b0);
    t_store(1'b0);
    t_load_use();
    t_mul();
    do_reset(1'b1);
    t_lanes(1'b1);
    t_store(1'b1);
    conclude();
  end
endmodule
